// ### hw/frm_pkg.sv
// constants and types shared by the fault response manager
package frm_pkg;
	localparam int NCH = 2;
	// register byte addresses
	localparam logic [7:0] ADDR_GCFG   = 8'h00;
	localparam logic [7:0] ADDR_OPER   = 8'h04;
	localparam logic [7:0] ADDR_CLR    = 8'h08;
	localparam logic [7:0] ADDR_AMASK  = 8'h0c;
	localparam logic [7:0] ADDR_STAT   = 8'h10;
	localparam logic [7:0] ADDR_RSP0   = 8'h14;
	localparam logic [7:0] ADDR_RETRY  = 8'h28;
	localparam logic [7:0] ADDR_TONLIM = 8'h2c;
	localparam logic [7:0] ADDR_PROP   = 8'h30;
	localparam logic [7:0] ADDR_IINLIM = 8'h34;
	localparam logic [7:0] ADDR_IINOFS = 8'h38;
	localparam logic [7:0] ADDR_IIN    = 8'h3c;
	localparam logic [7:0] ADDR_CHST   = 8'h40;
	// response registers in order: ov, uv, oc, start-up timer, fault pin
	localparam int NRSP   = 5;
	localparam int RSP_OV = 0;
	localparam int RSP_UV = 1;
	localparam int RSP_OC = 2;
	localparam int RSP_TON = 3;
	localparam int RSP_PIN = 4;
	// field positions
	localparam int GCFG_CLR_ALL = 0;
	localparam int GCFG_PEC     = 1;
	localparam int ST_OTHER = 8;
	localparam int ST_IIN   = 10;
	localparam int ST_COMM  = 11;
	localparam int ST_SUM   = 12;
	localparam int ST_ALERT = 15;
	localparam int PROP_PG  = 4;
	localparam int PROP_CH1 = 8;
	// actions
	localparam logic [1:0] ACT_NONE  = 2'h0;
	localparam logic [1:0] ACT_LATCH = 2'h1;
	localparam logic [1:0] ACT_RETRY = 2'h2;
	// timing
	localparam int CLK_NS     = 25;
	localparam int TICK_US    = 10;
	localparam int TICK_CYC   = (TICK_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int MS_NS      = 1000000;
	localparam int MS_CYC     = MS_NS / CLK_NS;
	localparam int OC_UNIT_MS = 16;
	localparam logic [16:0] RETRY_MIN_MS = 17'h00078;
	localparam logic [16:0] RETRY_MAX_MS = 17'h147a8;
	// reset values
	localparam logic [16:0] RST_RETRY  = 17'h00078;
	localparam logic [15:0] RST_TONLIM = 16'h0000;
	localparam logic [15:0] RST_AMASK  = 16'h0000;
	localparam logic [15:0] RST_IINLIM = 16'hffff;
	// synchroniser reset: fault pins sit at their pulled-up idle level
	localparam logic [9:0]  RST_SYNC   = 10'h300;
	typedef struct packed {
		logic [2:0] dglitch;
		logic [1:0] act;
	} frm_resp_t;
	typedef struct packed {
		logic [15:0] iout;
		logic [7:0]  duty;
	} frm_meas_t;
	typedef enum logic [1:0] {CH_OFF, CH_RUN, CH_WAIT, CH_LATCH} frm_chst_t;
endpackage : frm_pkg

// ### hw/frm_fault_mgr.sv
// fault response manager: detection, responses, fault pins, alert, apb
//
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module frm_fault_mgr #(
	parameter int MS_CYC = frm_pkg::MS_CYC
) (
	input  wire logic                   clk,
	input  wire logic                   resetn,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [7:0]             paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire logic [1:0]             run_pin,
	input  wire logic [1:0]             ov_cmp,
	input  wire logic [1:0]             uv_cmp,
	input  wire logic [1:0]             oc_cmp,
	input  wire logic [1:0]             fault_pin_i,
	output logic      [1:0]             fault_pin_o,
	output logic      [1:0]             fault_pin_oe,
	input  wire logic [1:0]             ss_begun,
	input  wire frm_pkg::frm_meas_t [1:0] meas,
	input  wire logic                   pec_err,
	input  wire logic                   unsup_cmd,
	input  wire logic                   bad_data,
	input  wire logic                   ara_read_ok,
	input  wire logic                   soft_reset_cmd,
	output logic                        alert_n,
	output logic      [1:0]             chan_switching,
	output logic      [1:0]             high_side_en,
	output logic      [1:0]             low_side_gate,
	output logic      [1:0]             soft_start
);
	localparam int MSW = $clog2(MS_CYC + 1);
	localparam int TKW = $clog2(frm_pkg::TICK_CYC + 1);

	logic [1:0]  gcfg_reg;
	logic [1:0]  oper_reg;
	logic [15:0] amask_reg;
	logic [15:0] stat_reg;
	logic        alert_reg;
	logic [16:0] retry_reg;
	logic [15:0] tonlim_reg;
	logic [15:0] prop_reg;
	logic [15:0] iinlim_reg;
	logic [15:0] iinofs_reg;
	logic [17:0] iin_reg;
	frm_pkg::frm_resp_t rsp_reg [frm_pkg::NRSP];
	logic [9:0]  s1_reg;
	logic [9:0]  s2_reg;
	logic [MSW-1:0] ms_cnt_reg;
	logic [TKW-1:0] us_cnt_reg;
	logic [3:0]  oc_cnt_reg;
	logic        ms_tick;
	logic        tick10;
	logic        tick16;
	logic        iin_warn_reg;
	logic [15:0] ev_prev_reg;
	logic [15:0] ev;
	logic [15:0] ev_new;
	logic [15:0] clr;
	logic        clr_all;
	logic        wr_go;
	logic        acc;
	logic [4:0]  ch_ev   [frm_pkg::NCH];
	logic [15:0] ch_clr  [frm_pkg::NCH];
	logic [1:0]  ch_st   [frm_pkg::NCH];
	logic [15:0] prod    [frm_pkg::NCH];
	logic        comm_ev;

	// two-flop synchronisers for every pin and comparator input
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			// a low pin here would read as an external pull after reset
			s1_reg <= frm_pkg::RST_SYNC;
			s2_reg <= frm_pkg::RST_SYNC;
		end else begin
			s1_reg <= {fault_pin_i, oc_cmp, uv_cmp, ov_cmp, run_pin};
			s2_reg <= s1_reg;
		end
	end

	// time bases: 10 us, 1 ms and 16 ms ticks
	assign tick10 = (us_cnt_reg == TKW'(frm_pkg::TICK_CYC - 1));
	assign ms_tick = (ms_cnt_reg == MSW'(MS_CYC - 1));
	assign tick16 = ms_tick && (oc_cnt_reg == 4'(frm_pkg::OC_UNIT_MS - 1));
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			us_cnt_reg <= '0;
			ms_cnt_reg <= '0;
			oc_cnt_reg <= '0;
		end else begin
			us_cnt_reg <= tick10 ? '0 : us_cnt_reg + 1'b1;
			ms_cnt_reg <= ms_tick ? '0 : ms_cnt_reg + 1'b1;
			if (ms_tick)
				oc_cnt_reg <= oc_cnt_reg + 4'h1;
		end
	end

	// apb slave: one wait state, pready and data from flops
	assign acc   = psel && penable;
	assign wr_go = acc && pready && pwrite;

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a <= frm_pkg::ADDR_CHST) && (a[1:0] == 2'b00);
	endfunction : mapped

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= acc && !pready;
			pslverr <= acc && !pready && !mapped(paddr);
			prdata  <= '0;
			if (acc && !pready && !pwrite) begin
				case (paddr)
				frm_pkg::ADDR_GCFG:   prdata <= {30'h0, gcfg_reg};
				frm_pkg::ADDR_OPER:   prdata <= {30'h0, oper_reg};
				frm_pkg::ADDR_AMASK:  prdata <= {16'h0, amask_reg};
				frm_pkg::ADDR_STAT:   prdata <= {16'h0, alert_reg, 2'h0,
				                                 |stat_reg[11:0],
				                                 stat_reg[11:0]};
				frm_pkg::ADDR_RETRY:  prdata <= {15'h0, retry_reg};
				frm_pkg::ADDR_TONLIM: prdata <= {16'h0, tonlim_reg};
				frm_pkg::ADDR_PROP:   prdata <= {16'h0, prop_reg};
				frm_pkg::ADDR_IINLIM: prdata <= {16'h0, iinlim_reg};
				frm_pkg::ADDR_IINOFS: prdata <= {16'h0, iinofs_reg};
				frm_pkg::ADDR_IIN:    prdata <= {14'h0, iin_reg};
				frm_pkg::ADDR_CHST:   prdata <= {28'h0, ch_st[1], ch_st[0]};
				default: begin
					for (int i = 0; i < frm_pkg::NRSP; i++)
						if (paddr == 8'(frm_pkg::ADDR_RSP0 + 4 * i))
							prdata <= {27'h0, rsp_reg[i]};
				end
				endcase
			end
		end
	end

	// configuration registers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			gcfg_reg   <= '0;
			oper_reg   <= '0;
			amask_reg  <= frm_pkg::RST_AMASK;
			retry_reg  <= frm_pkg::RST_RETRY;
			tonlim_reg <= frm_pkg::RST_TONLIM;
			prop_reg   <= '0;
			iinlim_reg <= frm_pkg::RST_IINLIM;
			iinofs_reg <= '0;
			for (int i = 0; i < frm_pkg::NRSP; i++)
				rsp_reg[i] <= '0;
		end else if (wr_go) begin
			case (paddr)
			frm_pkg::ADDR_GCFG:   gcfg_reg   <= pwdata[1:0];
			frm_pkg::ADDR_OPER:   oper_reg   <= pwdata[1:0];
			frm_pkg::ADDR_AMASK:  amask_reg  <= pwdata[15:0];
			frm_pkg::ADDR_TONLIM: tonlim_reg <= pwdata[15:0];
			frm_pkg::ADDR_PROP:   prop_reg   <= pwdata[15:0];
			frm_pkg::ADDR_IINLIM: iinlim_reg <= pwdata[15:0];
			frm_pkg::ADDR_IINOFS: iinofs_reg <= pwdata[15:0];
			frm_pkg::ADDR_RETRY: begin
				// out-of-range values are clamped, never stored
				if (pwdata[16:0] < frm_pkg::RETRY_MIN_MS || |pwdata[31:17])
					retry_reg <= pwdata[31:17] != '0 ? frm_pkg::RETRY_MAX_MS
					             : frm_pkg::RETRY_MIN_MS;
				else if (pwdata[16:0] > frm_pkg::RETRY_MAX_MS)
					retry_reg <= frm_pkg::RETRY_MAX_MS;
				else
					retry_reg <= pwdata[16:0];
			end
			default: begin
				for (int i = 0; i < frm_pkg::NRSP; i++)
					if (paddr == 8'(frm_pkg::ADDR_RSP0 + 4 * i))
						rsp_reg[i] <= pwdata[4:0];
			end
			endcase
		end
	end

	// input current estimate and warning
	genvar c;
	generate
		for (c = 0; c < frm_pkg::NCH; c++) begin : g_prod
			logic [23:0] p;
			assign p = meas[c].iout * meas[c].duty;
			assign prod[c] = p[23:8];
		end
	endgenerate
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			iin_reg      <= '0;
			iin_warn_reg <= 1'b0;
		end else begin
			iin_reg <= 18'(prod[0]) + 18'(prod[1])
			           + 18'({iinofs_reg, 1'b0});
			iin_warn_reg <= iin_reg > {2'h0, iinlim_reg};
		end
	end

	// status, events and alert
	assign comm_ev = (pec_err && gcfg_reg[frm_pkg::GCFG_PEC])
	                 || unsup_cmd || bad_data;
	assign ev = {4'h0, comm_ev, iin_warn_reg, ch_ev[1][4], ch_ev[0][4],
	             ch_ev[1][3:0], ch_ev[0][3:0]};
	assign ev_new = ev & ~ev_prev_reg;
	assign clr_all = (wr_go && paddr == frm_pkg::ADDR_CLR)
	                 || ara_read_ok || soft_reset_cmd;
	assign clr = (clr_all ? 16'hffff : 16'h0)
	             | (wr_go && paddr == frm_pkg::ADDR_STAT ? pwdata[15:0] : 16'h0)
	             | ch_clr[0] | ch_clr[1];

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ev_prev_reg <= '0;
			stat_reg    <= '0;
		end else begin
			ev_prev_reg <= ev;
			// a new event wins over a clear in the same cycle
			stat_reg <= (stat_reg & ~clr) | ev_new;
		end
	end

	// alert follows events only; the off/on channel clear leaves it alone
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			alert_reg <= 1'b0;
			alert_n   <= 1'b1;
		end else begin
			if (|(ev_new & ~amask_reg)) begin
				alert_reg <= 1'b1;
				alert_n   <= 1'b0;
			end else if (clr_all || (wr_go && paddr == frm_pkg::ADDR_STAT
			                          && pwdata[frm_pkg::ST_ALERT])) begin
				alert_reg <= 1'b0;
				alert_n   <= 1'b1;
			end
		end
	end

	// per-channel fault handling
	generate
		for (c = 0; c < frm_pkg::NCH; c++) begin : g_ch
			frm_pkg::frm_chst_t st_reg;
			logic        on_now;
			logic        on_prev_reg;
			logic        up_reg;
			logic [4:0]  cause_reg;
			logic [16:0] wait_reg;
			logic [15:0] ton_reg;
			logic [2:0]  oe_hist_reg;
			logic [2:0]  cond;
			logic [4:0]  trip;
			logic [4:0]  latch_v;
			logic [4:0]  retry_v;
			logic        ov_s;
			logic        uv_s;
			logic        oc_s;
			logic        pin_s;
			logic        ext_low;
			logic        pg;
			logic [4:0]  pmask;

			assign ov_s  = s2_reg[2 + c];
			assign uv_s  = s2_reg[4 + c];
			assign oc_s  = s2_reg[6 + c];
			assign pin_s = s2_reg[8 + c];
			assign on_now = s2_reg[c] && oper_reg[c];
			assign pmask = prop_reg[c * frm_pkg::PROP_CH1 +: 5];
			assign cond = {oc_s, uv_s && up_reg, ov_s};
			// only a low level we are not driving ourselves counts
			assign ext_low = !pin_s && !(|oe_hist_reg);
			assign pg = (st_reg == frm_pkg::CH_RUN) && up_reg
			            && !ov_s && !uv_s;

			genvar k;
			for (k = 0; k < 3; k++) begin : g_dg
				logic [2:0] cnt_reg;
				logic       tk;
				assign tk = (k == frm_pkg::RSP_OC) ? tick16 : tick10;
				always_ff @(posedge clk or negedge resetn) begin
					if (!resetn)
						cnt_reg <= '0;
					else if (!cond[k])
						cnt_reg <= '0;
					else if (tk && cnt_reg != 3'h7)
						cnt_reg <= cnt_reg + 3'h1;
				end
				assign trip[k] = cond[k]
				                 && cnt_reg >= rsp_reg[k].dglitch;
			end
			assign trip[frm_pkg::RSP_TON] = (st_reg == frm_pkg::CH_RUN)
			                                && tonlim_reg != '0
			                                && ton_reg >= tonlim_reg;
			assign trip[frm_pkg::RSP_PIN] = ext_low;

			for (k = 0; k < frm_pkg::NRSP; k++) begin : g_act
				// ov action none means pull-down only, oc none means limit
				assign latch_v[k] = trip[k]
				    && rsp_reg[k].act == frm_pkg::ACT_LATCH;
				assign retry_v[k] = trip[k]
				    && rsp_reg[k].act == frm_pkg::ACT_RETRY;
			end

			assign ch_ev[c] = {ext_low, trip[frm_pkg::RSP_TON], cond};
			assign ch_st[c] = st_reg;
			assign ch_clr[c] = !(on_now && !on_prev_reg) ? 16'h0
			    : gcfg_reg[frm_pkg::GCFG_CLR_ALL] ? 16'h1fff
			    : (16'h000f << (4 * c))
			      | (16'h0001 << (frm_pkg::ST_OTHER + c));

			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					st_reg     <= frm_pkg::CH_OFF;
					cause_reg  <= '0;
					wait_reg   <= '0;
					soft_start[c] <= 1'b0;
				end else begin
					soft_start[c] <= 1'b0;
					case (st_reg)
					frm_pkg::CH_OFF: begin
						cause_reg <= '0;
						if (on_now) begin
							st_reg <= frm_pkg::CH_RUN;
							soft_start[c] <= 1'b1;
						end
					end
					frm_pkg::CH_RUN: begin
						wait_reg <= '0;
						if (!on_now)
							st_reg <= frm_pkg::CH_OFF;
						else if (|latch_v) begin
							st_reg    <= frm_pkg::CH_LATCH;
							cause_reg <= latch_v | retry_v;
						end else if (|retry_v) begin
							st_reg    <= frm_pkg::CH_WAIT;
							cause_reg <= retry_v;
						end
					end
					frm_pkg::CH_WAIT: begin
						if (!on_now)
							st_reg <= frm_pkg::CH_OFF;
						else if (wait_reg >= retry_reg) begin
							wait_reg <= '0;
							// a fault still present restarts the wait
							if (!ov_s && !oc_s && !ext_low) begin
								st_reg    <= frm_pkg::CH_RUN;
								cause_reg <= '0;
								soft_start[c] <= 1'b1;
							end
						end else if (ms_tick)
							wait_reg <= wait_reg + 17'h1;
					end
					frm_pkg::CH_LATCH: begin
						if (!on_now)
							st_reg <= frm_pkg::CH_OFF;
					end
					default: st_reg <= frm_pkg::CH_OFF;
					endcase
				end
			end

			// start-up timer and output-up flag
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					on_prev_reg <= 1'b0;
					up_reg      <= 1'b0;
					ton_reg     <= '0;
				end else begin
					on_prev_reg <= on_now;
					if (st_reg != frm_pkg::CH_RUN) begin
						up_reg  <= 1'b0;
						ton_reg <= '0;
					end else if (!uv_s) begin
						up_reg <= 1'b1;
					end else if (!up_reg && ss_begun[c] && tick10
					             && ton_reg != 16'hffff) begin
						ton_reg <= ton_reg + 16'h1;
					end
				end
			end

			// power stage and open-drain fault pin
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					chan_switching[c] <= 1'b0;
					high_side_en[c]   <= 1'b0;
					low_side_gate[c]  <= 1'b0;
					fault_pin_o[c]    <= 1'b0;
					fault_pin_oe[c]   <= 1'b0;
					oe_hist_reg       <= '0;
				end else begin
					chan_switching[c] <= st_reg == frm_pkg::CH_RUN;
					high_side_en[c] <= st_reg == frm_pkg::CH_RUN
					                   && !ov_s;
					low_side_gate[c] <= ov_s;
					fault_pin_o[c] <= 1'b0;
					// pin response must be ignore in power-good mode; not forced here, the rsp_reg[RSP_PIN] action still applies
					if (pmask[frm_pkg::PROP_PG])
						fault_pin_oe[c] <= !pg;
					else
						fault_pin_oe[c] <= |(cause_reg[3:0]
						                     & pmask[3:0]);
					oe_hist_reg <= {oe_hist_reg[1:0], fault_pin_oe[c]};
				end
			end
		end
	endgenerate
endmodule : frm_fault_mgr

// ### tb/frm_peer.sv
// peer channels and pull-up sharing the two fault pins
`timescale 1ns/1ps
module frm_peer (
	input  wire logic [1:0] dut_oe,
	input  wire logic [1:0] peer_pull,
	output logic      [1:0] wire_lvl
);
	// open drain with pull-up: any low driver wins the wire
	assign wire_lvl = ~(dut_oe | peer_pull);
endmodule : frm_peer

// ### tb/frm_sva.sv
// assertions on the ports of the fault response manager
`timescale 1ns/1ps
module frm_sva (
	input wire logic       clk,
	input wire logic       resetn,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pwrite,
	input wire logic [7:0] paddr,
	input wire logic       pready,
	input wire logic       pslverr,
	input wire logic [1:0] ov_cmp,
	input wire logic       ara_read_ok,
	input wire logic       soft_reset_cmd,
	input wire logic       alert_n,
	input wire logic [1:0] fault_pin_oe,
	input wire logic [1:0] chan_switching,
	input wire logic [1:0] high_side_en,
	input wire logic [1:0] low_side_gate,
	input wire logic [1:0] soft_start
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	chk_ready_wait: assert property (
		pready |-> psel && penable && $past(penable))
		else $error("pready outside second access cycle");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_err_unmap: assert property (
		psel && penable && pready && paddr > 8'h40 |-> pslverr)
		else $error("unmapped access without error");
	chk_ov_lowside: assert property (
		$rose(ov_cmp[0]) |-> ##[1:4] low_side_gate[0])
		else $error("low side not forced on overvoltage");
	chk_ov_highside: assert property (
		$rose(low_side_gate[0]) |-> ##[0:1] !high_side_en[0])
		else $error("high side on during overvoltage");
	// clears land at the sampled strobe edge, so those cycles are exempt
	chk_alert_hold: assert property (
		!alert_n && !ara_read_ok && !soft_reset_cmd && !(psel && pwrite)
		|=> !alert_n)
		else $error("alert released without a clear");
	chk_reset_quiet: assert property (
		$rose(resetn) |-> fault_pin_oe == 2'h0 && alert_n)
		else $error("pins or alert driven after reset");
	chk_ss_pulse: assert property (
		soft_start[0] |=> !soft_start[0])
		else $error("soft start not a single pulse");
	chk_hs_stop: assert property (
		$fell(chan_switching[0]) |-> ##[0:1] !high_side_en[0])
		else $error("high side on after shutdown");
	cover property ($fell(alert_n));
	cover property (soft_start[0]);
	cover property (pslverr);
	cover property ($rose(fault_pin_oe[0]));
endmodule : frm_sva

bind frm_fault_mgr frm_sva u_sva (.clk, .resetn, .psel, .penable, .pwrite,
	.paddr, .pready, .pslverr, .ov_cmp, .ara_read_ok, .soft_reset_cmd,
	.alert_n, .fault_pin_oe, .chan_switching, .high_side_en,
	.low_side_gate, .soft_start);

// ### tb/frm_fault_mgr_tb.sv
// self-checking bench for the fault response manager
`timescale 1ns/1ps
module frm_fault_mgr_tb;
	// shortened millisecond so retry waits stay in the thousands of cycles
	localparam int MSC = 40;
	localparam int RW = 120 * MSC;
	localparam logic [7:0] ST = frm_pkg::ADDR_STAT, CH = frm_pkg::ADDR_CHST;
	localparam logic [7:0] A_OV = frm_pkg::ADDR_RSP0, A_PIN = 8'h24;
	localparam logic [7:0] GC = frm_pkg::ADDR_GCFG, CL = frm_pkg::ADDR_CLR;
	localparam logic [7:0] A_UV = 8'h18, A_OC = 8'h1c, A_TON = 8'h20;
	logic        clk, resetn, psel, penable, pwrite, pready, pslverr;
	logic        alert_n, last_err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic [1:0]  run_pin, ov_cmp, uv_cmp, oc_cmp, ss_begun, pull, pin_i;
	logic [1:0]  fault_pin_o, fault_pin_oe, chan_switching;
	logic [1:0]  high_side_en, low_side_gate, soft_start;
	logic [4:0]  ev;
	frm_pkg::frm_meas_t [1:0] meas;
	int          num_errors, checks_done, cyc;
	logic [31:0] exp_q[$], msk_q[$];

	frm_fault_mgr #(.MS_CYC(MSC)) u_frm_fault_mgr (.clk(clk),
		.resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .run_pin(run_pin), .ov_cmp(ov_cmp),
		.uv_cmp(uv_cmp), .oc_cmp(oc_cmp), .fault_pin_i(pin_i),
		.fault_pin_o(fault_pin_o), .fault_pin_oe(fault_pin_oe),
		.ss_begun(ss_begun), .meas(meas), .pec_err(ev[0]),
		.unsup_cmd(ev[1]), .bad_data(ev[2]), .ara_read_ok(ev[3]),
		.soft_reset_cmd(ev[4]), .alert_n(alert_n),
		.chan_switching(chan_switching), .high_side_en(high_side_en),
		.low_side_gate(low_side_gate), .soft_start(soft_start));
	frm_peer u_frm_peer (.dut_oe(fault_pin_oe), .peer_pull(pull),
		.wire_lvl(pin_i));

	task automatic close_out;
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : close_out
	task automatic chk_bit(input logic got, want, input string m);
		checks_done++;
		if (got !== want) begin
			num_errors++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask : chk_bit
	task automatic chk_rd(input logic [31:0] got, want, m);
		checks_done++;
		if ((got & m) !== want) begin
			num_errors++;
			$display("unexpected at %0t: read %h", $time, got);
		end
	endtask : chk_rd
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask : wt
	// request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		chk_bit(pready, 1'b1, "no bus answer");
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		apb(1'b0, a, 32'h0);
	endtask : rd
	task automatic pulse(input int k);
		ev[k] <= 1'b1;
		@(posedge clk);
		ev[k] <= 1'b0;
		wt(6);
	endtask : pulse
	task automatic toggle(input int c);
		run_pin[c] <= 1'b0;
		wt(8);
		run_pin[c] <= 1'b1;
		wt(16);
	endtask : toggle

	always @(posedge clk) begin
		if (pready === 1'b1 && psel && penable && !pwrite) begin
			if (exp_q.size() == 0) begin
				chk_bit(1'b0, 1'b1, "read with no note");
			end else begin
				chk_rd(prdata, exp_q.pop_front(), msk_q.pop_front());
			end
		end
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			num_errors++;
			close_out();
		end
	end
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial begin
		logic [2:0] dg;
		int n;
		{resetn, psel, penable, pwrite, paddr, pwdata, ev} = '0;
		{ov_cmp, uv_cmp, oc_cmp, pull, meas} = '0;
		run_pin = 2'h3;
		ss_begun = 2'h3;
		void'($urandom(89136));
		wt(6);
		resetn <= 1'b1;
		wt(2);
		chk_bit(alert_n, 1'b1, "alert at reset");
		chk_bit(fault_pin_oe[0] | fault_pin_oe[1], 1'b0, "pins");
		rd(frm_pkg::ADDR_RETRY, 32'h78, '1);
		rd(frm_pkg::ADDR_TONLIM, 32'h0, '1);
		rd(8'h44, 32'h0, '1);
		chk_bit(last_err, 1'b1, "unmapped");
		wr(frm_pkg::ADDR_RETRY, 32'h5);
		rd(frm_pkg::ADDR_RETRY, 32'h78, '1);
		wr(frm_pkg::ADDR_RETRY, 32'h1ffff);
		rd(frm_pkg::ADDR_RETRY, 32'h147a8, '1);
		wr(frm_pkg::ADDR_RETRY, 32'h78);
		wr(GC, 32'h2);
		// each comm source in turn, each pass releasing the alert a different way
		for (int i = 0; i < 4; i++) begin
			pulse(i % 3);
			chk_bit(alert_n, 1'b0, "comm alert");
			rd(ST, 32'h1800, 32'h1800);
			case (i)
				0: wr(CL, 32'h0);
				1: wr(ST, 32'h8000);
				2: pulse(3);
				default: pulse(4);
			endcase
			wt(4);
			chk_bit(alert_n, 1'b1, "alert release");
			wr(ST, 32'hffff);
		end
		wr(frm_pkg::ADDR_AMASK, 32'h800);
		pulse(2);
		chk_bit(alert_n, 1'b1, "masked alert");
		rd(ST, 32'h800, 32'h800);
		wr(frm_pkg::ADDR_AMASK, 32'h0);
		wr(frm_pkg::ADDR_IINLIM, 32'h100);
		wr(frm_pkg::ADDR_IINOFS, 32'h0);
		rd(ST, 32'h0, 32'h400);
		meas[0].iout <= 16'h4000 | 16'($urandom());
		meas[0].duty <= 8'h80;
		wt(20);
		rd(ST, 32'h400, 32'h400);
		chk_bit(alert_n, 1'b0, "input current alert");
		meas[0].iout <= 16'h0;
		wt(20);
		wr(CL, 32'h0);
		wr(A_PIN, 32'h0); // power-good pin must ignore its input
		wr(frm_pkg::ADDR_PROP, 32'h10);
		wt(8);
		chk_bit(fault_pin_oe[0], 1'b1, "not good while off");
		wr(frm_pkg::ADDR_OPER, 32'h3);
		wt(20);
		chk_bit(fault_pin_oe[0], 1'b0, "good while on");
		wr(frm_pkg::ADDR_PROP, 32'h1);
		wr(A_OV, 32'h0);
		ov_cmp[0] <= 1'b1;
		wt(8);
		chk_bit(low_side_gate[0], 1'b1, "ov low side");
		chk_bit(high_side_en[0], 1'b0, "ov high side");
		ov_cmp[0] <= 1'b0;
		wt(8);
		chk_bit(high_side_en[0], 1'b1, "high side back");
		rd(CH, 32'h1, 32'h3);
		rd(ST, 32'h1, 32'h1);
		toggle(1);
		rd(ST, 32'h1, 32'h1);
		wr(GC, 32'h3);
		toggle(1);
		rd(ST, 32'h0, 32'h1);
		wr(GC, 32'h2);
		// free-running tick: a glitch one unit short can never expire
		dg = 3'($urandom_range(7, 2));
		wr(A_OV, {27'h0, dg, frm_pkg::ACT_LATCH});
		ov_cmp[0] <= 1'b1;
		wt((int'(dg) - 1) * frm_pkg::TICK_CYC - 100);
		ov_cmp[0] <= 1'b0;
		wt(8);
		rd(CH, 32'h1, 32'h3);
		ov_cmp[0] <= 1'b1;
		wt(int'(dg) * frm_pkg::TICK_CYC + 100);
		ov_cmp[0] <= 1'b0;
		rd(CH, 32'h3, 32'h3);
		wt(20);
		chk_bit(fault_pin_oe[0], 1'b1, "latched pin");
		chk_bit(fault_pin_oe[1], 1'b0, "unmapped pin");
		toggle(0);
		rd(ST, 32'h0, 32'h1);
		rd(CH, 32'h1, 32'h3);
		chk_bit(fault_pin_oe[0], 1'b0, "pin freed");
		wr(A_OV, {30'h0, frm_pkg::ACT_RETRY});
		ov_cmp[0] <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (n == RW + 200) ov_cmp[0] <= 1'b0;
			if (n == RW - 800) chk_bit(fault_pin_oe[0], 1'b1, "wait pin");
		end while (soft_start[0] !== 1'b1 && n < 3 * RW);
		chk_bit(n > 2 * RW - 100 && n < 2 * RW + 100, 1'b1, "retry");
		wt(8);
		chk_bit(fault_pin_oe[0], 1'b0, "group release");
		rd(CH, 32'h1, 32'h3);
		wr(CL, 32'h0);
		wr(A_PIN, {30'h0, frm_pkg::ACT_LATCH});
		pull[0] <= 1'b1;
		wt(10);
		chk_bit(chan_switching[0], 1'b0, "pin shutdown");
		chk_bit(alert_n, 1'b0, "pin alert");
		pull[0] <= 1'b0;
		rd(ST, 32'h100, 32'h100);
		wr(A_PIN, 32'h0);
		toggle(0);
		chk_bit(chan_switching[0], 1'b1, "restart");
		// start-up timer: output never climbs above the uv limit
		wr(frm_pkg::ADDR_TONLIM, 32'h3);
		wr(A_TON, {30'h0, frm_pkg::ACT_LATCH});
		uv_cmp[0] <= 1'b1;
		toggle(0);
		wt(4 * frm_pkg::TICK_CYC);
		rd(CH, 32'h3, 32'h3);
		rd(ST, 32'h8, 32'h8);
		uv_cmp[0] <= 1'b0;
		toggle(0);
		// undervoltage once the output is up
		wr(A_UV, {30'h0, frm_pkg::ACT_LATCH});
		uv_cmp[0] <= 1'b1;
		wt(10);
		rd(CH, 32'h3, 32'h3);
		uv_cmp[0] <= 1'b0;
		toggle(0);
		// overcurrent deglitched by one 16 ms unit
		wr(A_OC, {27'h0, 3'h1, frm_pkg::ACT_LATCH});
		oc_cmp[0] <= 1'b1;
		wt(16 * MSC + 20);
		rd(CH, 32'h3, 32'h3);
		oc_cmp[0] <= 1'b0;
		chk_bit(|fault_pin_o, 1'b0, "pin data");
		close_out();
	end
endmodule : frm_fault_mgr_tb
